// File: core/ctlsup_pkg.sv
`default_nettype none
package ctlsup_pkg;
  // Timebase
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_MS     = 1000000;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int RB_TIMEOUT_MS = 20;
  localparam int RB_TICKS_INT  = RB_TIMEOUT_MS * NS_PER_MS / TICK_NS;
  localparam logic [4:0] RB_TICKS = 5'(RB_TICKS_INT);
  localparam int DIVCLK_W      = 16;
  localparam int CLK_BIT0      = 12;

  // Register byte addresses
  localparam logic [3:0] ADR_CFG_IN  = 4'h0;
  localparam logic [3:0] ADR_CFG_OUT = 4'h4;
  localparam logic [3:0] ADR_CFG_DIV = 4'h8;
  localparam logic [3:0] ADR_STATUS  = 4'hC;

  // Input configuration fields, one 16-bit slice per group
  localparam int IN_STRIDE    = 16;
  localparam int CHAR_LSB     = 0;
  localparam int CHAR_W       = 6;
  localparam int GROUPING_LSB = 6;
  localparam int ACTION_LSB   = 8;
  localparam int ACTION_W     = 5;
  // Output configuration fields
  localparam int FSEL_W       = 4;
  localparam int SSEL_LSB     = 16;
  localparam int SSEL_W       = 3;
  // Divergence configuration fields
  localparam int DEPTH_LSB    = 0;
  localparam int DEPTH_W      = 4;
  localparam int THR_LSB      = 4;
  localparam int THR_W        = 7;
  localparam int TOL_LSB      = 16;
  localparam int TOL_W        = 8;
  // Status fields
  localparam int ST_IN_ERR    = 0;
  localparam int ST_RB_ERR    = 1;
  localparam int ST_TRIP      = 2;
  localparam int ST_LEVEL_LSB = 8;
  localparam int ST_CNT_LSB   = 16;

  localparam logic [31:0] CFG_IN_RST  = 32'h008A008A;
  localparam logic [31:0] CFG_OUT_RST = 32'h00000000;
  localparam logic [31:0] CFG_DIV_RST = 32'h000A028A;

  // Configuration codes
  localparam logic [5:0] CHAR_BIP_MAX = 6'h07;
  localparam logic [5:0] CHAR_CLK_LO  = 6'h14;
  localparam logic [5:0] CHAR_CLK_HI  = 6'h23;
  localparam logic [1:0] GRP_PAIR     = 2'h1;
  localparam logic [1:0] GRP_SINGLE   = 2'h2;
  localparam logic [1:0] GROUPING_SEL = 2'h3;
  localparam logic [4:0] ACT_SHIFT    = 5'h0D;
  localparam logic [3:0] FSEL_CLOCK   = 4'h9;

  typedef enum logic [2:0] {
    SSEL_FIXED  = 3'h0,
    SSEL_GRAY_A = 3'h1,
    SSEL_BIN_A  = 3'h2,
    SSEL_GRAY_B = 3'h3,
    SSEL_BIN_B  = 3'h4
  } ctlsup_ssel_t;

  localparam logic [3:0] GRAY_CODE [4] = '{4'h0, 4'h1, 4'h3, 4'h2};

  // Divergence filter
  localparam logic [3:0] DEPTH_3  = 4'h3;
  localparam logic [3:0] DEPTH_5  = 4'h5;
  localparam logic [3:0] DEPTH_10 = 4'hA;
  localparam logic [6:0] PCT10    = 7'h0A;
  localparam logic [6:0] PCT20    = 7'h14;
  localparam logic [6:0] PCT30    = 7'h1E;
  localparam logic [6:0] PCT40    = 7'h28;
  localparam logic [6:0] DEP5_ADJ = 7'h04;
  // Trip counts for depth 3, indexed [threshold step][drop step]
  localparam logic [6:0] DEP3_TAB [4][4] = '{
    '{7'h09, 7'h04, 7'h03, 7'h02},
    '{7'h00, 7'h0D, 7'h07, 7'h05},
    '{7'h00, 7'h00, 7'h10, 7'h09},
    '{7'h00, 7'h00, 7'h00, 7'h12}};
endpackage
`default_nettype wire

// File: core/ctlsup_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - Depth ten trips after threshold periods
// R2 - Depth five, big drop: threshold minus four
// R3 - Depth three, 40 percent drop table
// R4 - Ten percent drop: nine or ten periods
// R5 - Twenty percent drop, depth three: 13/4
// R6 - Thirty percent drop, depth three: 16/7/3
// R7 - Unipolar unclocked: no check, no delay
// R8 - Unipolar clocked inputs watch clock source
// R9 - Missing clock raises readback error, 20 ms
// R10 - Bipolar pairs checked for illegal combinations
// R11 - Illegal state tolerated for tolerance ticks
// R12 - Clock source output uses function nine
// R13 - Clock output tracks driven inverse
// R14 - Output one fastest, output four slowest
// R15 - Either clock track usable, opposite phase
// R16 - Action thirteen gives two switching points
// R17 - Multi-point selection needs grouping three
// R18 - Select one/three: Gray from group A/B
// R19 - Select two/four: binary from group A/B
// R20 - Gray accepts four codes, else error
// R21 - Binary selection never raises error
// R22 - Each output picks its own source
// R23 - Evaluation period comes from tick strobe
// R24 - Illegal Gray keeps last valid point
// R25 - Counter advances on drop, clears otherwise
module ctlsup_top
  import ctlsup_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYC
)
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic [7:0]  i_ctl_in,
  input  wire logic        i_eval_tick,
  input  wire logic [6:0]  i_drop_pct,
  output logic      [7:0]  o_ctl_level,
  output logic      [3:0]  o_clk_trk,
  output logic      [3:0]  o_clk_trk_n,
  output logic      [15:0] o_point,
  output logic      [1:0]  o_shift,
  output logic             o_in_err,
  output logic             o_rb_err,
  output logic             o_div_trip
);
  localparam int TW = $clog2(P_TICK_CYCLES + 1);

  typedef struct packed {
    logic [7:0]          s1;
    logic [7:0]          s2;
    logic [7:0]          prev;
    logic [31:0]         cfg_in;
    logic [31:0]         cfg_out;
    logic [31:0]         cfg_div;
    logic                ack;
    logic [31:0]         rdat;
    logic [TW-1:0]       tick_cnt;
    logic                tick;
    logic [DIVCLK_W-1:0] div_clk;
    logic [3:0]          clk_p;
    logic [3:0]          clk_n;
    logic [7:0][4:0]     rb_cnt;
    logic [1:0][7:0]     ill_cnt;
    logic [1:0][1:0]     gray_pt;
    logic [3:0][3:0]     point;
    logic [1:0]          shift;
    logic [6:0]          div_cnt;
    logic                in_err;
    logic                rb_err;
    logic                trip;
  } ctlsup_state_t;

  ctlsup_state_t st_reg;
  ctlsup_state_t st_next;

  // Trip count for the configured depth, threshold and present drop
  function automatic logic [6:0] trip_limit(input logic [3:0] dep,
                                            input logic [6:0] thr,
                                            input logic [6:0] drop);
    logic [1:0] b;
    logic [1:0] t;
    logic       hit;
    b   = (drop >= PCT40) ? 2'h3 : (drop >= PCT30) ? 2'h2 :
          (drop >= PCT20) ? 2'h1 : 2'h0;
    t   = 2'h0;
    hit = 1'b1;
    case (thr)
      PCT10:   t = 2'h0;
      PCT20:   t = 2'h1;
      PCT30:   t = 2'h2;
      PCT40:   t = 2'h3;
      default: hit = 1'b0;
    endcase
    trip_limit = thr; // R1
    if (dep == DEPTH_3 && hit)
    begin
      trip_limit = DEP3_TAB[t][b]; // R3 R4 R5 R6
    end
    else if (dep == DEPTH_5 && hit && b == 2'h3)
    begin
      trip_limit = thr - DEP5_ADJ; // R2
    end
  endfunction

  always_comb
  begin
    logic [5:0]   chr;
    logic [1:0]   grp;
    logic [1:0]   grp_a;
    logic [1:0]   grp_b;
    logic [4:0]   act;
    logic [3:0]   v;
    logic [3:0]   fsel;
    ctlsup_ssel_t ssel;
    logic         ill;
    logic         any_gray;
    logic         gvalid;
    logic [1:0]   gidx;
    logic         wr;
    logic         rd;
    logic [3:0]   depth;
    logic [6:0]   thr;
    logic [7:0]   tol;
    logic [6:0]   limit;
    logic [31:0]  st_w;
    chr      = '0;
    grp      = '0;
    act      = '0;
    v        = '0;
    fsel     = '0;
    ssel     = SSEL_FIXED;
    ill      = 1'b0;
    any_gray = 1'b0;
    gvalid   = 1'b0;
    gidx     = '0;
    st_w     = '0;
    wr       = 1'b0;
    rd       = 1'b0;
    limit    = '0;
    st_next  = st_reg;
    grp_a    = st_reg.cfg_in[GROUPING_LSB +: 2];
    grp_b    = st_reg.cfg_in[IN_STRIDE + GROUPING_LSB +: 2];
    depth    = st_reg.cfg_div[DEPTH_LSB +: DEPTH_W];
    thr      = st_reg.cfg_div[THR_LSB +: THR_W];
    tol      = st_reg.cfg_div[TOL_LSB +: TOL_W];

    // Pin synchronisers; s1 feeds s2 only
    st_next.s1   = i_ctl_in;
    st_next.s2   = st_reg.s1;
    st_next.prev = st_reg.s2;

    // Millisecond tick and clock generator counter
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == TW'(P_TICK_CYCLES - 1))
    begin
      st_next.tick_cnt = '0;
      st_next.tick     = 1'b1;
    end
    else
    begin
      st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
    end
    st_next.div_clk = st_reg.div_clk + 1'b1;

    // Wishbone classic slave, one wait state
    wr = i_wb_cyc && i_wb_stb && !st_reg.ack && i_wb_we;
    rd = i_wb_cyc && i_wb_stb && !st_reg.ack && !i_wb_we;
    st_next.ack = i_wb_cyc && i_wb_stb && !st_reg.ack;
    st_w[ST_IN_ERR] = st_reg.in_err;
    st_w[ST_RB_ERR] = st_reg.rb_err;
    st_w[ST_TRIP]   = st_reg.trip;
    st_w[ST_LEVEL_LSB +: 8] = st_reg.s2;
    st_w[ST_CNT_LSB +: 7]   = st_reg.div_cnt;
    st_next.rdat = '0;
    if (rd)
    begin
      case (i_wb_adr)
        ADR_CFG_IN:  st_next.rdat = st_reg.cfg_in;
        ADR_CFG_OUT: st_next.rdat = st_reg.cfg_out;
        ADR_CFG_DIV: st_next.rdat = st_reg.cfg_div;
        ADR_STATUS:  st_next.rdat = st_w;
        default:     st_next.rdat = '0;
      endcase
    end
    for (int b = 0; b < 4; b++)
    begin
      if (wr && i_wb_sel[b])
      begin
        case (i_wb_adr)
          ADR_CFG_IN:  st_next.cfg_in[8*b +: 8]  = i_wb_dat[8*b +: 8];
          ADR_CFG_OUT: st_next.cfg_out[8*b +: 8] = i_wb_dat[8*b +: 8];
          ADR_CFG_DIV: st_next.cfg_div[8*b +: 8] = i_wb_dat[8*b +: 8];
          default:     st_next.rdat = st_next.rdat;
        endcase
      end
    end
    // Error clears come first so a same-cycle set wins
    if (wr && i_wb_adr == ADR_STATUS && i_wb_sel[0])
    begin
      if (i_wb_dat[ST_IN_ERR])
      begin
        st_next.in_err = 1'b0;
      end
      if (i_wb_dat[ST_RB_ERR])
      begin
        st_next.rb_err = 1'b0;
      end
    end

    // Clock source outputs, lower rate for higher index
    for (int k = 0; k < 4; k++)
    begin
      fsel = st_reg.cfg_out[FSEL_W*k +: FSEL_W];
      if (fsel == FSEL_CLOCK) // R12
      begin
        st_next.clk_p[k] = st_reg.div_clk[CLK_BIT0 + k]; // R14
        st_next.clk_n[k] = !st_reg.div_clk[CLK_BIT0 + k]; // R13 R15
      end
      else
      begin
        st_next.clk_p[k] = 1'b0;
        st_next.clk_n[k] = 1'b0;
      end
    end

    // Per input group checks
    for (int g = 0; g < 2; g++)
    begin
      chr = st_reg.cfg_in[IN_STRIDE*g + CHAR_LSB +: CHAR_W];
      grp = st_reg.cfg_in[IN_STRIDE*g + GROUPING_LSB +: 2];
      act = st_reg.cfg_in[IN_STRIDE*g + ACTION_LSB +: ACTION_W];
      v   = st_reg.s2[4*g +: 4];
      any_gray = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
        ssel = ctlsup_ssel_t'(st_reg.cfg_out[SSEL_LSB + SSEL_W*k +: SSEL_W]);
        if ((g == 0 && ssel == SSEL_GRAY_A) ||
            (g == 1 && ssel == SSEL_GRAY_B))
        begin
          any_gray = 1'b1;
        end
      end
      gvalid = 1'b0;
      gidx   = '0;
      for (int j = 0; j < 4; j++)
      begin
        if (v == GRAY_CODE[j])
        begin
          gvalid = 1'b1;
          gidx   = 2'(j);
        end
      end
      ill = 1'b0;
      if (grp == GROUPING_SEL && any_gray && !gvalid)
      begin
        ill = 1'b1; // R20
      end
      if (grp <= GRP_PAIR && chr <= CHAR_BIP_MAX)
      begin
        // Bit 0 clear: inverse pair, set: homogeneous pair
        if (chr[0] ? (v[0] != v[1] || v[2] != v[3])
                   : (v[0] == v[1] || v[2] == v[3]))
        begin
          ill = 1'b1; // R10
        end
      end
      if (grp == GROUPING_SEL && gvalid)
      begin
        st_next.gray_pt[g] = gidx; // R24
      end
      if (!ill)
      begin
        st_next.ill_cnt[g] = '0;
      end
      else if (st_reg.tick && st_reg.ill_cnt[g] != 8'hFF)
      begin
        st_next.ill_cnt[g] = st_reg.ill_cnt[g] + 1'b1;
      end
      if (ill && st_reg.ill_cnt[g] > tol)
      begin
        st_next.in_err = 1'b1; // R11
      end
      // Clocked inputs must keep toggling
      for (int i = 0; i < 4; i++)
      begin
        if (chr >= CHAR_CLK_LO && chr <= CHAR_CLK_HI &&
            (grp == GRP_PAIR || grp == GRP_SINGLE)) // R8
        begin
          if (st_reg.s2[4*g+i] != st_reg.prev[4*g+i])
          begin
            st_next.rb_cnt[4*g+i] = '0;
          end
          else if (st_reg.tick && st_reg.rb_cnt[4*g+i] != RB_TICKS)
          begin
            st_next.rb_cnt[4*g+i] = st_reg.rb_cnt[4*g+i] + 1'b1;
          end
          if (st_reg.rb_cnt[4*g+i] == RB_TICKS)
          begin
            st_next.rb_err = 1'b1; // R9
          end
        end
        else
        begin
          st_next.rb_cnt[4*g+i] = '0;
        end
      end
      st_next.shift[g] = (act == ACT_SHIFT && grp_a != GROUPING_SEL &&
                          grp_b != GROUPING_SEL) ? v[0] : 1'b0; // R16
    end

    // Switching point per output
    for (int k = 0; k < 4; k++)
    begin
      ssel = ctlsup_ssel_t'(st_reg.cfg_out[SSEL_LSB + SSEL_W*k +: SSEL_W]);
      case (ssel) // R22
        SSEL_GRAY_A:
          st_next.point[k] = (grp_a == GROUPING_SEL) ?
                             {2'h0, st_next.gray_pt[0]} : 4'h0; // R18 R17
        SSEL_BIN_A:
          st_next.point[k] = (grp_a == GROUPING_SEL) ?
                             st_reg.s2[3:0] : 4'h0; // R19 R21
        SSEL_GRAY_B:
          st_next.point[k] = (grp_b == GROUPING_SEL) ?
                             {2'h0, st_next.gray_pt[1]} : 4'h0; // R18
        SSEL_BIN_B:
          st_next.point[k] = (grp_b == GROUPING_SEL) ?
                             st_reg.s2[7:4] : 4'h0; // R19
        default:
          st_next.point[k] = 4'h0;
      endcase
    end

    // Divergence trip filter, advanced once per evaluation period
    limit = trip_limit(depth, thr, i_drop_pct);
    if (i_eval_tick) // R23
    begin
      if (thr != '0 && i_drop_pct >= thr)
      begin
        if (st_reg.div_cnt < limit)
        begin
          st_next.div_cnt = st_reg.div_cnt + 1'b1; // R25
        end
      end
      else
      begin
        st_next.div_cnt = '0; // R25
      end
    end
    st_next.trip = (st_next.div_cnt >= limit) && (st_next.div_cnt != '0);
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg         <= '0;
      st_reg.cfg_in  <= CFG_IN_RST;
      st_reg.cfg_out <= CFG_OUT_RST;
      st_reg.cfg_div <= CFG_DIV_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_wb_dat    = st_reg.rdat;
  assign o_wb_ack    = st_reg.ack;
  assign o_ctl_level = st_reg.s2; // R7
  assign o_clk_trk   = st_reg.clk_p;
  assign o_clk_trk_n = st_reg.clk_n;
  assign o_point     = st_reg.point;
  assign o_shift     = st_reg.shift;
  assign o_in_err    = st_reg.in_err;
  assign o_rb_err    = st_reg.rb_err;
  assign o_div_trip  = st_reg.trip;

  // Checks
  logic [3:0] a_dep;
  logic [6:0] a_thr;
  logic       a_gok0;
  assign a_dep  = st_reg.cfg_div[DEPTH_LSB +: DEPTH_W];
  assign a_thr  = st_reg.cfg_div[THR_LSB +: THR_W];
  assign a_gok0 = (st_reg.s2[3:0] == GRAY_CODE[0]) ||
                  (st_reg.s2[3:0] == GRAY_CODE[1]) ||
                  (st_reg.s2[3:0] == GRAY_CODE[2]) ||
                  (st_reg.s2[3:0] == GRAY_CODE[3]);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_trip_rise;
    $rose(o_div_trip) && $stable(st_reg.cfg_div);
  endsequence
  sequence s_d3_rise;
    s_trip_rise ##0 (a_dep == DEPTH_3);
  endsequence

  property p_trip_d10;
    s_trip_rise ##0 (a_dep == DEPTH_10) |-> st_reg.div_cnt == a_thr;
  endproperty
  a_trip_d10: assert property (p_trip_d10) // R1
    else $error("depth ten trip count wrong");

  property p_trip_d5;
    s_trip_rise ##0 (a_dep == DEPTH_5 && a_thr == PCT40 &&
                     $past(i_drop_pct) >= PCT40)
      |-> st_reg.div_cnt == a_thr - DEP5_ADJ;
  endproperty
  a_trip_d5: assert property (p_trip_d5) // R2
    else $error("depth five trip count wrong");

  property p_trip_d3_40;
    s_d3_rise ##0 (a_thr == PCT40 && $past(i_drop_pct) >= PCT40)
      |-> st_reg.div_cnt == DEP3_TAB[3][3];
  endproperty
  a_trip_d3_40: assert property (p_trip_d3_40) // R3
    else $error("depth three trip count wrong at 40");

  property p_trip_d3_10;
    s_d3_rise ##0 (a_thr == PCT10 && $past(i_drop_pct) < PCT20)
      |-> st_reg.div_cnt == DEP3_TAB[0][0];
  endproperty
  a_trip_d3_10: assert property (p_trip_d3_10) // R4
    else $error("depth three trip count wrong at 10");

  property p_trip_d3_20;
    s_d3_rise ##0 (a_thr == PCT20 && $past(i_drop_pct) >= PCT20 &&
                   $past(i_drop_pct) < PCT30)
      |-> st_reg.div_cnt == DEP3_TAB[1][1];
  endproperty
  a_trip_d3_20: assert property (p_trip_d3_20) // R5
    else $error("depth three trip count wrong at 20");

  property p_trip_d3_30;
    s_d3_rise ##0 (a_thr == PCT30 && $past(i_drop_pct) >= PCT30 &&
                   $past(i_drop_pct) < PCT40)
      |-> st_reg.div_cnt == DEP3_TAB[2][2];
  endproperty
  a_trip_d3_30: assert property (p_trip_d3_30) // R6
    else $error("depth three trip count wrong at 30");

  property p_div_clear;
    i_eval_tick && i_drop_pct < a_thr |=> st_reg.div_cnt == '0 && !o_div_trip;
  endproperty
  a_div_clear: assert property (p_div_clear) // R25
    else $error("divergence counter not cleared");

  property p_clk_inverse;
    $past(st_reg.cfg_out[FSEL_W-1:0]) == FSEL_CLOCK
      |-> o_clk_trk_n[0] != o_clk_trk[0];
  endproperty
  a_clk_inverse: assert property (p_clk_inverse) // R13
    else $error("clock tracks not in opposite phase");

  property p_gray_hold;
    st_reg.cfg_in[GROUPING_LSB +: 2] == GROUPING_SEL && !a_gok0
      |=> $stable(st_reg.gray_pt[0]);
  endproperty
  a_gray_hold: assert property (p_gray_hold) // R24
    else $error("gray point changed on illegal code");

  property p_shift;
    st_reg.cfg_in[ACTION_LSB +: ACTION_W] == ACT_SHIFT &&
    st_reg.cfg_in[GROUPING_LSB +: 2] != GROUPING_SEL &&
    st_reg.cfg_in[IN_STRIDE + GROUPING_LSB +: 2] != GROUPING_SEL
      |=> o_shift[0] == $past(st_reg.s2[0]);
  endproperty
  a_shift: assert property (p_shift) // R16
    else $error("two point shift does not follow input");
endmodule
`default_nettype wire

// File: verif/ctlsup_field.sv
`timescale 1ns/1ps
`default_nettype none
module ctlsup_field
(
  input  wire logic [7:0] i_sw,
  input  wire logic       i_fb_on,
  input  wire logic [3:0] i_clk_trk_n,
  output logic      [7:0] o_ctl_in
);
  // Closed contact loops the inverse clock track onto the second group;
  // an open contact leaves the static switch level, so no edges arrive
  assign o_ctl_in = i_fb_on ? {{4{i_clk_trk_n[0]}}, i_sw[3:0]} : i_sw;
endmodule
`default_nettype wire

// File: verif/ctlsup_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ctlsup_top_tb
  import ctlsup_pkg::*;
;
  localparam int TK = 250;
  // Entries: depth, threshold, drop, periods to trip
  localparam logic [27:0] DC [17] = '{
    28'hA282828, 28'h5282824, 28'h51E281A, 28'h5142810, 28'h50A2806,
    28'h3282812, 28'h31E2809, 28'h3142805, 28'h30A2802, 28'h30A0A09,
    28'h50A0A0A, 28'hA0A0A0A, 28'h314140D, 28'h30A1404, 28'h31E1E10,
    28'h3141E07, 28'h30A1E03};
  logic        i_clock     = 1'b0;
  logic        i_rst_n     = 1'b0;
  logic        i_wb_cyc    = 1'b0;
  logic        i_wb_stb    = 1'b0;
  logic        i_wb_we     = 1'b0;
  logic [3:0]  i_wb_adr    = 4'h0;
  logic [3:0]  i_wb_sel    = 4'h0;
  logic [31:0] i_wb_dat    = 32'h0;
  logic        i_eval_tick = 1'b0;
  logic [6:0]  i_drop_pct  = 7'h00;
  logic [7:0]  sw          = 8'h00;
  logic        fb_on       = 1'b0;
  wire  [7:0]  i_ctl_in;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic [7:0]  o_ctl_level;
  logic [3:0]  o_clk_trk;
  logic [3:0]  o_clk_trk_n;
  logic [15:0] o_point;
  logic [1:0]  o_shift;
  logic        o_in_err;
  logic        o_rb_err;
  logic        o_div_trip;
  int          n_fail      = 0;
  int          n_compared  = 0;

  always #12.5 i_clock = ~i_clock;

  ctlsup_top #(.P_TICK_CYCLES(TK)) DUT (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_ctl_in(i_ctl_in), .i_eval_tick(i_eval_tick),
    .i_drop_pct(i_drop_pct), .o_ctl_level(o_ctl_level),
    .o_clk_trk(o_clk_trk), .o_clk_trk_n(o_clk_trk_n), .o_point(o_point),
    .o_shift(o_shift), .o_in_err(o_in_err), .o_rb_err(o_rb_err),
    .o_div_trip(o_div_trip));

  ctlsup_field FIELD (.i_sw(sw), .i_fb_on(fb_on),
    .i_clk_trk_n(o_clk_trk_n), .o_ctl_in(i_ctl_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= 4'hF;
    @(posedge i_clock);
    while (o_wb_ack !== 1'b1)
    begin
      @(posedge i_clock);
    end
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic tick(input logic [6:0] d);
    i_eval_tick <= 1'b1;
    i_drop_pct  <= d;
    @(posedge i_clock);
    i_eval_tick <= 1'b0;
    cyc_n(2);
  endtask

  // Illegal state must survive three ticks, then latch until cleared
  task automatic errwin(input logic [7:0] good);
    cyc_n(2 * TK);
    chk(o_in_err, 1'b0);
    cyc_n(5 * TK);
    chk(o_in_err, 1'b1);
    sw <= good;
    cyc_n(4);
    wr(ADR_STATUS, 32'h00000001);
    cyc_n(2);
    chk(o_in_err, 1'b0);
  endtask

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (80000) @(posedge i_clock);
    n_fail++;
    close_out();
  end

  initial
  begin : main
    logic [27:0] e;
    logic [3:0]  p;
    logic [3:0]  c;
    int          bad;
    int          c0;
    int          c3;
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    rd(ADR_CFG_IN, CFG_IN_RST);
    rd(ADR_CFG_OUT, CFG_OUT_RST);
    rd(ADR_CFG_DIV, CFG_DIV_RST);
    rd(4'h2, 32'h0);
    $display("test registers done");

    wr(ADR_CFG_DIV, 32'h0003028A);
    sw <= 8'h5A;
    cyc_n(4);
    chk(o_ctl_level, 8'h5A);
    cyc_n(8 * TK);
    chk(o_in_err, 1'b0);
    $display("test unipolar done");

    wr(ADR_CFG_IN, 32'h008A0D8A);
    sw <= 8'h01;
    cyc_n(5);
    chk(o_shift, 2'h1);
    sw <= 8'h00;
    cyc_n(5);
    chk(o_shift, 2'h0);
    sw <= 8'h01;
    wr(ADR_CFG_IN, 32'h00CA0D8A);
    cyc_n(5);
    chk(o_shift, 2'h0);
    $display("test shift done");

    wr(ADR_CFG_IN, 32'h00CA00CA);
    wr(ADR_CFG_OUT, 32'h00210000);
    for (int i = 0; i < 4; i++)
    begin
      sw <= {4'h0, GRAY_CODE[i]};
      cyc_n(5);
      chk(o_point[3:0], 4'(i));
    end
    sw <= 8'h05;
    cyc_n(5);
    chk(o_point[3:0], 4'h3);
    errwin({4'h0, GRAY_CODE[1]});
    $display("test gray done");

    for (int v = 0; v < 16; v++)
    begin
      sw <= {4'(v), GRAY_CODE[1]};
      cyc_n(5);
      chk(o_point[7:0], {4'(v), 4'h1});
      chk(o_in_err, 1'b0);
    end
    $display("test binary done");

    wr(ADR_CFG_IN, 32'h008A0040);
    sw <= 8'h0A;
    cyc_n(8 * TK);
    chk(o_in_err, 1'b0);
    chk(o_point[3:0], 4'h0);
    sw <= 8'h0B;
    errwin(8'h0A);
    $display("test bipolar done");

    foreach (DC[i])
    begin
      e = DC[i];
      wr(ADR_CFG_DIV, (32'h3 << TOL_LSB) | (32'(e[22:16]) << THR_LSB)
                      | 32'(e[27:24]));
      tick(7'h00);
      repeat (int'(e[7:0]) - 1) tick(e[14:8]);
      chk(o_div_trip, 1'b0);
      tick(e[14:8]);
      chk(o_div_trip, 1'b1);
      tick(7'h00);
      chk(o_div_trip, 1'b0);
    end
    $display("test divergence done");

    wr(ADR_CFG_IN, 32'h008A008A);
    wr(ADR_CFG_OUT, 32'h00009009);
    bad = 0;
    c0  = 0;
    c3  = 0;
    p   = o_clk_trk;
    repeat (20000)
    begin
      @(posedge i_clock);
      c = o_clk_trk;
      if ((c ^ o_clk_trk_n) !== 4'h9 || (c & 4'h6) !== 4'h0)
        bad++;
      if (c[0] !== p[0])
        c0++;
      if (c[3] !== p[3])
        c3++;
      p = c;
    end
    chk(bad, 0);
    chk(c0 >= 4 && c0 > c3, 1'b1);
    $display("test clock outputs done");

    fb_on <= 1'b1;
    wr(ADR_CFG_IN, 32'h0094008A);
    cyc_n(60 * TK);
    chk(o_rb_err, 1'b0);
    fb_on <= 1'b0;
    cyc_n(24 * TK);
    chk(o_rb_err, 1'b1);
    fb_on <= 1'b1;
    cyc_n(20 * TK);
    wr(ADR_STATUS, 32'h00000002);
    cyc_n(2);
    chk(o_rb_err, 1'b0);
    $display("test clocked input done");
    close_out();
  end
endmodule
`default_nettype wire
